// >>> core/vic_pkg.sv
`default_nettype none
package vic_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_SELECT = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;

    // Field positions in the flags register
    localparam int FLAGS_GATE_POS = 16;
    localparam int FLAGS_ARM_POS = 17;

    // Counts of sources and slots
    localparam int NUM_FLAGS = 9;
    localparam int NUM_SLOTS = 8;

    // Request flag indices; slots 0 to 6 map one to one
    localparam logic [3:0] IDX_EXT0 = 4'h0;
    localparam logic [3:0] IDX_EXT1 = 4'h1;
    localparam logic [3:0] IDX_TMR1 = 4'h2;
    localparam logic [3:0] IDX_TMR2 = 4'h3;
    localparam logic [3:0] IDX_TMR3 = 4'h4;
    localparam logic [3:0] IDX_TMR5 = 4'h5;
    localparam logic [3:0] IDX_ADC = 4'h6;
    localparam logic [3:0] IDX_TMR4 = 4'h7;
    localparam logic [3:0] IDX_SERIAL = 4'h8;

    // Values after reset
    localparam logic [3:0] CTRL1_RESET = 4'h0;
    localparam logic [3:0] CTRL2_RESET = 4'h0;
    localparam logic SELECT_RESET = 1'b0;
    localparam logic [8:0] FLAGS_RESET = 9'h000;
    localparam logic [8:0] MASK_RESET = 9'h000;

    // Vector page and the width of the in-page address
    localparam int VEC_PAGE = 1;
    localparam int PCL_W = 7;

    // Machine cycles from conditions met to interrupt taken
    localparam int TAKE_CYCLES_SINGLE = 2;
    localparam int TAKE_CYCLES_MULTI = 3;
    localparam logic [1:0] WAIT_SINGLE = 2'(TAKE_CYCLES_SINGLE - 2);
    localparam logic [1:0] WAIT_MULTI = 2'(TAKE_CYCLES_MULTI - 2);

    // Take sequencer states
    typedef enum logic [0:0] {
        VIC_IDLE,
        VIC_WAIT
    } vic_state_type;
endpackage : vic_pkg
`default_nettype wire

// >>> core/vic_prio.sv
`default_nettype none
module vic_prio #(
    parameter int SLOTS = 8
) (
    input wire logic [SLOTS-1:0] pending_in,  // Enabled pending slots
    output logic any_out,  // At least one slot pending
    output logic [2:0] index_out  // Highest priority slot, 0 highest
);
    // Lowest index wins; scan from the bottom of the priority order
    always_comb begin
        any_out = 1'b0;
        index_out = 3'h0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (pending_in[i]) begin
                any_out = 1'b1;
                index_out = 3'(i);
            end
        end
    end
endmodule : vic_prio
`default_nettype wire

// >>> core/vic_ctrl.sv
// What this block does
// R1 - Take only if flag, enable, gate set
// R2 - Enable instruction sets gate, disable clears
// R3 - Taking an interrupt clears the gate, unless an armed enable completes in the same cycle
// R4 - Flags set regardless of any enables
// R5 - Flags hold until taken or skipped
// R6 - Pending request fires once gate reopens
// R7 - Fixed priority, external zero highest
// R8 - Vector in page one, even addresses
// R9 - Enable zero makes skip test valid
// R10 - Two control nibbles hold eight enables
// R11 - Pin edges, underflows, conversions set flags
// R12 - Last slot shared by timer four, serial
// R13 - Select zero timer four, one serial
// R14 - Take two or three cycles later
// R15 - Push return, save context, clear served
// R16 - Enable acts after one more instruction
// R17 - Valid skip test skips and clears
// R18 - Reset clears flags, enables and gate
`default_nettype none
module vic_ctrl #(
    parameter int PC_W = 14
) (
    input wire logic sys_clk_in,  // Machine-cycle clock
    input wire logic rst_in,  // Asynchronous reset, active high
    // Wishbone classic slave
    input wire logic wb_cyc_in,  // Bus cycle
    input wire logic wb_stb_in,  // Strobe
    input wire logic wb_we_in,  // Write enable
    input wire logic [7:0] wb_adr_in,  // Byte address
    input wire logic [3:0] wb_sel_in,  // Byte lanes
    input wire logic [31:0] wb_dat_in,  // Write data
    output logic [31:0] wb_dat_out,  // Read data
    output logic wb_ack_out,  // Acknowledge
    // Event sources
    input wire logic ext_pin_zero_in,  // External pin 0 level
    input wire logic ext_pin_one_in,  // External pin 1 level
    input wire logic tmr1_uflow_in,  // Timer 1 underflow pulse
    input wire logic tmr2_uflow_in,  // Timer 2 underflow pulse
    input wire logic tmr3_uflow_in,  // Timer 3 underflow pulse
    input wire logic tmr4_uflow_in,  // Timer 4 underflow pulse
    input wire logic tmr5_uflow_in,  // Timer 5 underflow pulse
    input wire logic adc_done_in,  // Conversion complete pulse
    input wire logic serial_done_in,  // Transmit/receive complete pulse
    // Instruction sequencer
    input wire logic irq_enable_instr_in,  // Enable instruction executes
    input wire logic irq_off_instr_in,  // Disable instruction executes
    input wire logic instr_done_in,  // An instruction completes
    input wire logic instr_multi_in,  // Current instruction is multi-cycle
    input wire logic skip_test_in,  // Skip-test instruction strobe
    input wire logic [3:0] skip_src_in,  // Flag index under test
    output logic skip_out,  // Skip the next instruction
    output logic irq_take_out,  // Interrupt taken, one cycle
    output logic [PC_W-1:0] vector_out,  // New program counter value
    output logic [2:0] irq_src_out,  // Slot served
    output logic stack_push_out,  // Push return address
    output logic irq_context_save_out,  // Save pointer, carry, skip, A, B
    output logic global_irq_gate_out,  // Global gate state
    output logic irq_line_out  // Unmasked status pending
);
    // Software-visible control
    logic [3:0] ctrl1;
    logic [3:0] ctrl2;
    logic shared_slot_select;
    logic [8:0] status;
    logic [8:0] mask;

    // Request flags and gate
    logic [8:0] req_flags;
    logic global_irq_gate;
    logic gate_armed;

    // Event detection
    logic ext0_prev;
    logic ext1_prev;
    logic pins_valid;
    logic [8:0] events;

    // Take sequencer
    vic_pkg::vic_state_type state;
    logic [1:0] wait_cnt;
    logic take_now;

    // Derived gating
    logic [8:0] src_en;
    logic [7:0] slot_pending;
    logic slot_any;
    logic [2:0] slot_idx;
    logic take_cond;
    logic [8:0] take_clr;
    logic [8:0] skip_clr;
    logic skip_valid;
    logic skip_hit;

    // Bus decode
    logic bus_req;
    logic bus_wr;

    // Single bit from a flag-indexed vector; indices past the end read zero
    function automatic logic flag_bit(input logic [8:0] vec, input logic [3:0] idx);
        flag_bit = (idx < 4'(vic_pkg::NUM_FLAGS)) ? vec[idx] : 1'b0;
    endfunction

    // Even address in the vector page for a slot
    function automatic logic [PC_W-1:0] slot_vector(input logic [2:0] idx);
        logic [PC_W-1:0] base;
        base = PC_W'(vic_pkg::VEC_PAGE) << vic_pkg::PCL_W;
        slot_vector = base | PC_W'({idx, 1'b0});
    endfunction

    // Merge low write data, bits 7:0 under the byte lane 0 strobe and bit 8 under lane 1
    function automatic logic [8:0] lane_merge(input logic [8:0] old, input logic [3:0] sel,
                                              input logic [31:0] dat);
        lane_merge = {sel[1] ? dat[8] : old[8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    // R11 pin level changes
    assign events[0] = pins_valid & (ext_pin_zero_in ^ ext0_prev);
    assign events[1] = pins_valid & (ext_pin_one_in ^ ext1_prev);
    // R11 underflows and completions
    assign events[2] = tmr1_uflow_in;
    assign events[3] = tmr2_uflow_in;
    assign events[4] = tmr3_uflow_in;
    assign events[5] = tmr5_uflow_in;
    assign events[6] = adc_done_in;
    assign events[7] = tmr4_uflow_in;
    assign events[8] = serial_done_in;

    // Pin history for edge detection; the first sample only primes it
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ext0_prev <= 1'b0;
            ext1_prev <= 1'b0;
            pins_valid <= 1'b0;
        end else begin
            ext0_prev <= ext_pin_zero_in;
            ext1_prev <= ext_pin_one_in;
            pins_valid <= 1'b1;
        end
    end

    // R10 enable layout per flag
    assign src_en = {ctrl2[3], ctrl2[3], ctrl2[2], ctrl2[1], ctrl2[0],
                     ctrl1[3], ctrl1[2], ctrl1[1], ctrl1[0]};

    // R12 shared slot source
    // R13 select chooses
    assign slot_pending[7] = (shared_slot_select ? req_flags[vic_pkg::IDX_SERIAL]
                                                 : req_flags[vic_pkg::IDX_TMR4]) & ctrl2[3];
    assign slot_pending[6:0] = req_flags[6:0] & src_en[6:0];

    // R7 fixed priority order
    vic_prio #(
        .SLOTS(vic_pkg::NUM_SLOTS)
    ) u_prio (
        .pending_in(slot_pending),
        .any_out(slot_any),
        .index_out(slot_idx)
    );

    // R1 three conditions together
    // R6 pending fires later
    assign take_cond = global_irq_gate & slot_any;

    // R14 delay count reached
    assign take_now = (state == vic_pkg::VIC_WAIT) && take_cond && (wait_cnt == 2'h0);

    // R15 only the served flag clears
    always_comb begin
        take_clr = 9'h000;
        if (take_now) begin
            if (slot_idx == 3'h7) begin
                take_clr[shared_slot_select ? vic_pkg::IDX_SERIAL : vic_pkg::IDX_TMR4] = 1'b1;
            end else begin
                take_clr[slot_idx] = 1'b1;
            end
        end
    end

    // R9 skip valid when disabled
    assign skip_valid = skip_test_in & ~flag_bit(src_en, skip_src_in);
    // R17 skip on set flag
    assign skip_hit = skip_valid & flag_bit(req_flags, skip_src_in);

    // Flag cleared by a successful skip test
    always_comb begin
        skip_clr = 9'h000;
        if (skip_hit) begin
            skip_clr[skip_src_in] = 1'b1;
        end
    end

    // R4 set regardless of enables
    // R5 hold until cleared; a new event wins over the clear
    // R18 flags clear at reset
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_flags <= vic_pkg::FLAGS_RESET;
        end else begin
            req_flags <= (req_flags & ~(take_clr | skip_clr)) | events;
        end
    end

    // Skip answer to the sequencer
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            skip_out <= 1'b0;
        end else begin
            skip_out <= skip_hit;
        end
    end

    // R2 enable and disable instructions
    // R16 enable waits one instruction
    // R3 taking clears gate, unless gate_armed and instr_done_in reopen it in the same cycle
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            global_irq_gate <= 1'b0;
            gate_armed <= 1'b0;
        end else if (irq_off_instr_in) begin
            global_irq_gate <= 1'b0;
            gate_armed <= 1'b0;
        end else if (irq_enable_instr_in) begin
            gate_armed <= 1'b1;
            global_irq_gate <= global_irq_gate & ~take_now;
        end else if (gate_armed && instr_done_in) begin
            gate_armed <= 1'b0;
            global_irq_gate <= 1'b1;
        end else if (take_now) begin
            global_irq_gate <= 1'b0;
        end
    end

    // R14 two or three cycle wait
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= vic_pkg::VIC_IDLE;
            wait_cnt <= 2'h0;
        end else begin
            unique case (state)
                vic_pkg::VIC_IDLE: begin
                    if (take_cond) begin
                        state <= vic_pkg::VIC_WAIT;
                        wait_cnt <= instr_multi_in ? vic_pkg::WAIT_MULTI : vic_pkg::WAIT_SINGLE;
                    end
                end
                vic_pkg::VIC_WAIT: begin
                    if (!take_cond || take_now) begin
                        state <= vic_pkg::VIC_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt - 2'h1;
                    end
                end
            endcase
        end
    end

    // R8 vector load
    // R15 push and context save
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_take_out <= 1'b0;
            stack_push_out <= 1'b0;
            irq_context_save_out <= 1'b0;
            vector_out <= '0;
            irq_src_out <= 3'h0;
        end else begin
            irq_take_out <= take_now;
            stack_push_out <= take_now;
            irq_context_save_out <= take_now;
            if (take_now) begin
                vector_out <= slot_vector(slot_idx);
                irq_src_out <= slot_idx;
            end
        end
    end

    // Bus request, answered one cycle later
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign bus_wr = bus_req & wb_we_in;

    // Acknowledge every access, mapped or not
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= bus_req;
        end
    end

    // R10 control nibbles
    // R18 enables clear at reset
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl1 <= vic_pkg::CTRL1_RESET;
            ctrl2 <= vic_pkg::CTRL2_RESET;
            shared_slot_select <= vic_pkg::SELECT_RESET;
        end else if (bus_wr && wb_sel_in[0]) begin
            if (wb_adr_in == vic_pkg::ADDR_CTRL1) begin
                ctrl1 <= wb_dat_in[3:0];
            end
            if (wb_adr_in == vic_pkg::ADDR_CTRL2) begin
                ctrl2 <= wb_dat_in[3:0];
            end
            if (wb_adr_in == vic_pkg::ADDR_SELECT) begin
                shared_slot_select <= wb_dat_in[0];
            end
        end
    end

    // Mask register
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask <= vic_pkg::MASK_RESET;
        end else if (bus_wr && wb_adr_in == vic_pkg::ADDR_MASK) begin
            mask <= lane_merge(mask, wb_sel_in, wb_dat_in);
        end
    end

    // Sticky event status, write one to clear; a new event wins
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status <= vic_pkg::FLAGS_RESET;
        end else if (bus_wr && wb_adr_in == vic_pkg::ADDR_STATUS) begin
            status <= (status & ~lane_merge(9'h000, wb_sel_in, wb_dat_in)) | events;
        end else begin
            status <= status | events;
        end
    end

    // Read data mux; unmapped reads return zero
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (bus_req && !wb_we_in) begin
            unique case (wb_adr_in)
                vic_pkg::ADDR_CTRL1: wb_dat_out <= {28'h000_0000, ctrl1};
                vic_pkg::ADDR_CTRL2: wb_dat_out <= {28'h000_0000, ctrl2};
                vic_pkg::ADDR_SELECT: wb_dat_out <= {31'h0000_0000, shared_slot_select};
                vic_pkg::ADDR_FLAGS: begin
                    wb_dat_out <= 32'h0000_0000;
                    wb_dat_out[8:0] <= req_flags;
                    wb_dat_out[vic_pkg::FLAGS_GATE_POS] <= global_irq_gate;
                    wb_dat_out[vic_pkg::FLAGS_ARM_POS] <= gate_armed;
                end
                vic_pkg::ADDR_STATUS: wb_dat_out <= {23'h00_0000, status};
                vic_pkg::ADDR_MASK: wb_dat_out <= {23'h00_0000, mask};
                default: wb_dat_out <= 32'h0000_0000;
            endcase
        end
    end

    // Status outputs
    assign global_irq_gate_out = global_irq_gate;
    assign irq_line_out = |(status & mask);
endmodule : vic_ctrl
`default_nettype wire

// >>> bench/vic_ctrl_assertions.sv
`default_nettype none
module vic_ctrl_assertions #(
    parameter int PC_W = 14
) (
    input wire logic sys_clk_in,  // Clock
    input wire logic rst_in,  // Reset
    input wire logic irq_off_instr_in,  // Disable instruction
    input wire logic instr_done_in,  // Instruction completes
    input wire logic skip_test_in,  // Skip-test strobe
    input wire logic [3:0] skip_src_in,  // Flag under test
    input wire logic skip_out,  // Skip result
    input wire logic irq_take_out,  // Take pulse
    input wire logic [PC_W-1:0] vector_out,  // Vector
    input wire logic [2:0] irq_src_out,  // Slot served
    input wire logic stack_push_out,  // Push
    input wire logic irq_context_save_out,  // Context save
    input wire logic global_irq_gate_out,  // Gate
    input wire logic irq_line_out  // Interrupt line
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking vic_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    AST_TAKE_NEEDS_GATE: assert property (irq_take_out |-> $past(global_irq_gate_out))
        else $error("Take while gate was shut");
    AST_TAKE_SHUTS_GATE: assert property (irq_take_out |-> !global_irq_gate_out)
        else $error("Gate open in take cycle");
    AST_TAKE_ONE_CYCLE: assert property (irq_take_out |=> !irq_take_out)
        else $error("Take longer than one cycle");
    AST_VECTOR_PAGE: assert property (irq_take_out |->
        vector_out == PC_W'({irq_src_out, 1'b0}) + PC_W'(8'h80))
        else $error("Vector does not match slot");
    AST_PUSH_SAVE: assert property ((stack_push_out == irq_take_out)
        && (irq_context_save_out == irq_take_out))
        else $error("Push or save apart from take");
    AST_OFF_CLOSES: assert property (irq_off_instr_in |=> !global_irq_gate_out)
        else $error("Gate open after disable");
    AST_GATE_OPEN_CAUSE: assert property ($rose(global_irq_gate_out) |->
        $past(instr_done_in))
        else $error("Gate opened without instruction end");
    // no take sooner than two cycles
    AST_NO_EARLY_TAKE: assert property ($rose(global_irq_gate_out) |->
        !irq_take_out ##1 !irq_take_out)
        else $error("Take too early after gate opened");
    AST_SKIP_CAUSE: assert property (skip_out |->
        $past(skip_test_in) && ($past(skip_src_in) <= 4'h8))
        else $error("Skip without skip test");

    COV_TAKE: cover property (irq_take_out);
    COV_SKIP: cover property (skip_out);
    COV_LINE: cover property ($rose(irq_line_out));
endmodule  // vic_ctrl_assertions
`default_nettype wire

// >>> bench/vic_seq_model.sv
`default_nettype none
module vic_seq_model (
    input wire logic sys_clk_in,  // Clock
    input wire logic rst_in,  // Reset
    input wire logic multi_in,  // Bench asks for long instructions
    input wire logic irq_take_in,  // Take pulse
    output logic instr_done_out,  // Instruction completes
    output logic instr_multi_out,  // Current instruction is long
    output logic [7:0] take_count_out  // Takes seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;

    // Every fourth cycle one instruction ends
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase <= 2'h0;
            instr_done_out <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            instr_done_out <= (phase == 2'h2);
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            instr_multi_out <= 1'b0;
        end else begin
            instr_multi_out <= multi_in;
        end
    end

    // Counts branches to a vector
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            take_count_out <= 8'h00;
        end else if (irq_take_in) begin
            take_count_out <= take_count_out + 8'h01;
        end
    end
endmodule  // vic_seq_model
`default_nettype wire

// >>> bench/tb_vic_ctrl.sv
`default_nettype none
module tb_vic_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC_W = 14;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [8:0] evt = 9'h000;
    logic en_instr = 1'b0;
    logic off_instr = 1'b0;
    logic stest = 1'b0;
    logic multi = 1'b0;
    logic [3:0] ssrc = 4'h0;
    logic [31:0] wb_dat_out;
    logic wb_ack_out, skip_out, irq_take_out, stack_push_out, irq_context_save_out;
    logic global_irq_gate_out, irq_line_out, done, imulti;
    logic [PC_W-1:0] vector_out;
    logic [2:0] irq_src_out;
    logic [7:0] tcount;
    int failures = 0;
    int comparisons = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    vic_ctrl #(.PC_W(PC_W)) dut (
        .sys_clk_in, .rst_in, .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out, .wb_ack_out,
        .ext_pin_zero_in(evt[0]), .ext_pin_one_in(evt[1]), .tmr1_uflow_in(evt[2]),
        .tmr2_uflow_in(evt[3]), .tmr3_uflow_in(evt[4]), .tmr5_uflow_in(evt[5]),
        .adc_done_in(evt[6]), .tmr4_uflow_in(evt[7]), .serial_done_in(evt[8]),
        .irq_enable_instr_in(en_instr), .irq_off_instr_in(off_instr), .instr_done_in(done),
        .instr_multi_in(imulti), .skip_test_in(stest), .skip_src_in(ssrc), .skip_out,
        .irq_take_out, .vector_out, .irq_src_out, .stack_push_out, .irq_context_save_out,
        .global_irq_gate_out, .irq_line_out
    );

    vic_seq_model u_seq (
        .sys_clk_in, .rst_in, .multi_in(multi), .irq_take_in(irq_take_out),
        .instr_done_out(done), .instr_multi_out(imulti), .take_count_out(tcount)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One classic Wishbone cycle, held until ack
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 20);
        q = wb_dat_out;
        req <= 1'b0;
        we <= 1'b0;
        if (n >= 20) check(1'b0, 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
        @(negedge sys_clk_in);
    endtask

    // Pins toggle, other sources pulse one cycle
    task automatic fire(input int i);
        @(posedge sys_clk_in);
        evt[i] <= ~evt[i];
        if (i > 1) begin
            @(posedge sys_clk_in);
            evt[i] <= 1'b0;
        end
    endtask

    task automatic skip_try(input logic [3:0] s);
        @(posedge sys_clk_in);
        stest <= 1'b1;
        ssrc <= s;
        @(posedge sys_clk_in);
        stest <= 1'b0;
        @(negedge sys_clk_in);
    endtask

    // Enable, then measure gate-to-take delay and vector
    task automatic enable_take(input logic [2:0] slot);
        int n;
        @(posedge sys_clk_in);
        en_instr <= 1'b1;
        @(posedge sys_clk_in);
        en_instr <= 1'b0;
        n = 0;
        // Gate cannot open in the cycle of the enable instruction
        @(negedge sys_clk_in);
        check(global_irq_gate_out, 1'b0);
        while (global_irq_gate_out !== 1'b1 && n < 50) begin
            @(negedge sys_clk_in);
            n++;
        end
        n = 0;
        while (irq_take_out !== 1'b1 && n < 10) begin
            @(negedge sys_clk_in);
            n++;
        end
        check(32'(n), multi ? 32'h3 : 32'h2);
        check(32'(vector_out), 32'h80 + 32'(slot) * 2);
        check(32'(irq_src_out), 32'(slot));
        check(global_irq_gate_out, 1'b0);
        check(stack_push_out, 1'b1);
        check(irq_context_save_out, 1'b1);
    endtask

    initial begin
        logic [31:0] d;
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        // everything clear, unmapped place reads zero
        for (int a = 0; a < 28; a += 4) begin
            wb_cycle(1'b0, 8'(a), 32'h0, d);
            check(d, 32'h0);
        end
        // flags set while everything is off
        for (int i = 0; i < 9; i++) fire(i);
        wb_cycle(1'b0, vic_pkg::ADDR_FLAGS, 32'h0, d);
        check(d, 32'h1FF);
        check(32'(tcount), 32'h0);
        // Index past the last flag never skips, all flags set
        skip_try(4'h9);
        check(skip_out, 1'b0);
        // Status is sticky, masked onto the line, cleared by one
        @(negedge sys_clk_in);
        check(irq_line_out, 1'b0);
        wr(vic_pkg::ADDR_MASK, 32'h001);
        check(irq_line_out, 1'b1);
        wr(vic_pkg::ADDR_STATUS, 32'h1FF);
        check(irq_line_out, 1'b0);
        // valid skip test skips and clears
        for (int i = 0; i < 9; i++) begin
            skip_try(4'(i));
            check(skip_out, 1'b1);
        end
        wb_cycle(1'b0, vic_pkg::ADDR_FLAGS, 32'h0, d);
        check(d, 32'h0);
        skip_try(4'h0);
        check(skip_out, 1'b0);
        wr(vic_pkg::ADDR_CTRL1, 32'h1);
        fire(0);
        skip_try(4'h0);
        check(skip_out, 1'b0);
        wb_cycle(1'b0, vic_pkg::ADDR_FLAGS, 32'h0, d);
        check(d, 32'h1);
        // all enables on, shared slot to timer four
        wr(vic_pkg::ADDR_CTRL1, 32'hF);
        wr(vic_pkg::ADDR_CTRL2, 32'hF);
        wr(vic_pkg::ADDR_SELECT, 32'h0);
        for (int i = 1; i < 9; i++) fire(i);
        // disable right after enable keeps gate shut
        @(posedge sys_clk_in);
        en_instr <= 1'b1;
        @(posedge sys_clk_in);
        en_instr <= 1'b0;
        off_instr <= 1'b1;
        @(posedge sys_clk_in);
        off_instr <= 1'b0;
        repeat (12) @(posedge sys_clk_in);
        check(global_irq_gate_out, 1'b0);
        check(32'(tcount), 32'h0);
        // pending requests served one by one in priority
        for (int k = 0; k < 8; k++) begin
            multi <= k[0];
            enable_take(3'(k));
        end
        wb_cycle(1'b0, vic_pkg::ADDR_FLAGS, 32'h0, d);
        check(d, 32'h100);
        // select one hands the slot to serial
        multi <= 1'b0;
        wr(vic_pkg::ADDR_SELECT, 32'h1);
        enable_take(3'h7);
        wb_cycle(1'b0, vic_pkg::ADDR_FLAGS, 32'h0, d);
        check(d, 32'h0);
        check(32'(tcount), 32'h9);
        test_done;
    end

    // Cuts a hang short
    initial begin
        repeat (6000) @(posedge sys_clk_in);
        failures++;
        test_done;
    end
endmodule  // tb_vic_ctrl

bind vic_ctrl vic_ctrl_assertions #(.PC_W(PC_W)) u_vic_chk (
    .sys_clk_in, .rst_in, .irq_off_instr_in, .instr_done_in, .skip_test_in, .skip_src_in,
    .skip_out, .irq_take_out, .vector_out, .irq_src_out, .stack_push_out,
    .irq_context_save_out, .global_irq_gate_out, .irq_line_out
);
`default_nettype wire
